// ---- hwcl_host.sv ----
`default_nettype none
module hwcl_host
    import hwcl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output var  hwcl_req_t  req,
    output var  logic       spi_chip_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req = '0;
        spi_chip_select_n = 1'b1;
    end
    // ----------------------------------------------------------------
    // one frame per byte; chip select rises as each frame closes
    // ----------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        spi_chip_select_n = 1'b0;
        req = {1'b1, a, d};
        @(posedge clk) #1;
        req.wr = 1'b0;
        spi_chip_select_n = 1'b1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        spi_chip_select_n = 1'b0;
        req.addr = a;
        @(posedge clk) #1;
        d = rd_data;
        spi_chip_select_n = 1'b1;
    endtask
    // open the level-0 lock first, or the pin write would be dropped
    task automatic pin_set(input logic [2:0] m);
        logic [7:0] v;
        rd(HW_ONE_ADDR, v);
        wr(HW_ONE_ADDR, v & ~LOCK0_MASK);
        wr(PIN_CFG_ADDR, {5'h00, m});
    endtask
endmodule
`default_nettype wire

// ---- hwcl_pkg.sv ----
`default_nettype none
package hwcl_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W          = 7;
    localparam int unsigned DATA_W          = 8;
    localparam logic [6:0]  HW_ONE_ADDR     = 7'h0e;
    localparam logic [6:0]  HW_TWO_ADDR     = 7'h0f;
    localparam logic [6:0]  PIN_CFG_ADDR    = 7'h17;
    localparam logic [7:0]  HW_ONE_POR      = 8'h00;
    localparam logic [7:0]  HW_TWO_POR      = 8'h40;
    localparam logic [7:0]  PIN_CFG_POR     = 8'h00;
    // ----------------------------------------------------------------
    // field positions and masks
    // ----------------------------------------------------------------
    localparam int unsigned UV_HYS_BIT      = 7;
    localparam int unsigned THERM_SEL_BIT   = 5;
    localparam int unsigned RST_DEL_BIT     = 4;
    localparam int unsigned LOCK0_BIT       = 3;
    localparam int unsigned FREQ_LSB        = 5;
    localparam int unsigned PEAK_BIT        = 4;
    localparam int unsigned SS_LSB          = 2;
    localparam int unsigned LOCK1_BIT       = 0;
    localparam logic [7:0]  HW_ONE_RW_MASK  = 8'hb8;
    localparam logic [7:0]  LOCK0_MASK      = 8'h08;
    localparam logic [7:0]  HW_TWO_RW_MASK  = 8'hfd;
    localparam logic [7:0]  PIN_CFG_RW_MASK = 8'h07;
    localparam logic [7:0]  NO_BITS         = 8'h00;
    // ----------------------------------------------------------------
    // thermal wait timing
    // ----------------------------------------------------------------
    localparam longint      CLK_HZ          = 100_000_000;
    localparam longint      WAIT_TIME_S     = 1;
    localparam longint      WAIT_CYCLES     = WAIT_TIME_S * CLK_HZ;
    localparam logic [6:0]  EXTEND_FACTOR   = 7'h40;
    localparam logic [4:0]  EXTEND_AFTER    = 5'h10;
    localparam logic [4:0]  COUNT_MAX       = 5'h1f;
    // ----------------------------------------------------------------
    // encodings and carriers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FREQ_1M8 = 3'h0,
        FREQ_2M0 = 3'h1,
        FREQ_2M2 = 3'h2,
        FREQ_2M4 = 3'h3
    } hwcl_freq_t;
    typedef enum logic [2:0] {
        PIN_FAIL_A = 3'h0, PIN_FAIL_B = 3'h1, PIN_FAIL_C = 3'h2,
        PIN_CYCLIC = 3'h3, PIN_OFF    = 3'h4, PIN_WAKE   = 3'h5,
        PIN_PWM_LS = 3'h6, PIN_PWM_HS = 3'h7
    } hwcl_pin_mode_t;
    typedef enum logic [1:0] {
        TSD_IDLE = 2'h0,
        TSD_WAIT = 2'h1
    } hwcl_tsd_state_t;
    typedef struct packed {
        logic                 wr;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
    } hwcl_req_t;
    typedef struct packed {
        logic                 uv_hys_highest;
        logic                 thermal_wait_extend_sel;
        logic                 reset_delay_reduced;
        logic [2:0]           pump_osc_freq_sel;
        logic                 pump_freq_reserved;
        logic                 peak_threshold_high;
        logic                 spread_spectrum_on;
        logic [1:0]           spread_spectrum_rate;
        logic                 fail_output;
        logic                 cyclic_sense;
        logic                 pin_off;
        logic                 wake_input;
        logic                 pwm_low_side;
        logic                 pwm_high_side;
        logic                 wake_source_fail_safe;
        logic                 pump_pin_locked;
        logic                 level1_locked;
    } hwcl_cfg_t;
endpackage
`default_nettype wire

// ---- hwcl_regs.sv ----
`default_nettype none
module hwcl_regs
    import hwcl_pkg::*;
#(
    parameter longint TSD_WAIT_CYCLES = WAIT_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire hwcl_req_t           req,
    input  wire logic                spi_chip_select_n,
    input  wire logic                soft_reset,
    input  wire logic                fail_safe_mode,
    input  wire logic                severe_thermal_shutdown_event,
    input  wire logic                severe_thermal_shutdown_count_clear,
    output var  logic [DATA_W-1:0]   rd_data,
    output var  hwcl_cfg_t           cfg,
    output var  logic                severe_thermal_shutdown_release_ok
);
    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (TSD_WAIT_CYCLES < 1 || TSD_WAIT_CYCLES > 134_217_727) begin : g_chk
        $error("wait cycle count outside the 27-bit prescaler range");
    end

    localparam logic [26:0] PRESC_LAST = 27'(TSD_WAIT_CYCLES - 1);

    // ----------------------------------------------------------------
    // register bank state
    // ----------------------------------------------------------------
    logic [7:0]      hw1_reg;
    logic [7:0]      hw1_next;
    logic [7:0]      hw2_reg;
    logic [7:0]      hw2_next;
    logic [7:0]      pin_reg;
    logic [7:0]      pin_next;
    logic            lock1_active_reg;
    logic            lock1_active_next;
    logic            cs_prev_reg;
    logic            cs_prev_next;
    logic [7:0]      hw1_wmask;
    logic [7:0]      hw2_wmask;
    logic [7:0]      pin_wmask;
    logic            lock0;
    logic            lock1_bit;

    assign lock0     = hw1_reg[LOCK0_BIT];
    assign lock1_bit = hw2_reg[LOCK1_BIT];

    always_comb begin
        hw1_next          = hw1_reg;
        hw2_next          = hw2_reg;
        pin_next          = pin_reg;
        cs_prev_next      = spi_chip_select_n;
        lock1_active_next = lock1_active_reg;
        // the level-0 lock bit itself stays writable at all times
        hw1_wmask = lock1_active_reg ? LOCK0_MASK : HW_ONE_RW_MASK;
        hw2_wmask = lock1_active_reg ? NO_BITS : HW_TWO_RW_MASK;
        pin_wmask = lock0 ? NO_BITS : PIN_CFG_RW_MASK;
        if (req.wr) begin
            // per-field masking: locked bits drop, the rest update
            if (req.addr == HW_ONE_ADDR) begin
                hw1_next = (hw1_reg & ~hw1_wmask)
                         | (req.wdata & hw1_wmask);
            end
            if (req.addr == HW_TWO_ADDR) begin
                hw2_next = (hw2_reg & ~hw2_wmask)
                         | (req.wdata & hw2_wmask);
            end
            if (req.addr == PIN_CFG_ADDR) begin
                pin_next = (pin_reg & ~pin_wmask)
                         | (req.wdata & pin_wmask);
            end
        end
        // soft reset wins over a write arriving in the same cycle, except to control one and two while the level-1 lock bit is set
        if (soft_reset) begin
            if (!lock1_bit) begin
                hw1_next = hw1_reg & LOCK0_MASK;
                hw2_next = HW_TWO_POR;
            end
            pin_next = lock0 ? (pin_reg & PIN_CFG_RW_MASK)
                             : PIN_CFG_POR;
        end
        // arming uses the bit as it stood before this edge
        if (!cs_prev_reg && spi_chip_select_n && lock1_bit) begin
            lock1_active_next = 1'b1;
        end
    end

    // sleep and fail-safe exits do not touch the bank, only rst_b and soft_reset do
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hw1_reg          <= HW_ONE_POR;
            hw2_reg          <= HW_TWO_POR;
            pin_reg          <= PIN_CFG_POR;
            lock1_active_reg <= 1'b0;
            cs_prev_reg      <= 1'b1;
        end else begin
            hw1_reg          <= hw1_next;
            hw2_reg          <= hw2_next;
            pin_reg          <= pin_next;
            lock1_active_reg <= lock1_active_next;
            cs_prev_reg      <= cs_prev_next;
        end
    end

    // ----------------------------------------------------------------
    // severe thermal shutdown waiting time
    // ----------------------------------------------------------------
    hwcl_tsd_state_t tsd_state_reg;
    hwcl_tsd_state_t tsd_state_next;
    logic [4:0]      evt_cnt_reg;
    logic [4:0]      evt_cnt_next;
    logic [26:0]     presc_reg;
    logic [26:0]     presc_next;
    logic [6:0]      secs_reg;
    logic [6:0]      secs_next;
    logic            release_next;

    always_comb begin
        tsd_state_next = tsd_state_reg;
        evt_cnt_next   = evt_cnt_reg;
        presc_next     = presc_reg;
        secs_next      = secs_reg;
        if (severe_thermal_shutdown_count_clear) begin
            evt_cnt_next = 5'h00;
        end
        // a new event in the clearing cycle counts from zero
        if (severe_thermal_shutdown_event && evt_cnt_next != COUNT_MAX) begin
            evt_cnt_next = evt_cnt_next + 5'h01;
        end else if (severe_thermal_shutdown_event) begin
            evt_cnt_next = COUNT_MAX;
        end
        case (tsd_state_reg)
            TSD_IDLE: begin
                if (severe_thermal_shutdown_event) begin
                    tsd_state_next = TSD_WAIT;
                    presc_next     = 27'h000_0000;
                    if (hw1_reg[THERM_SEL_BIT]
                        && evt_cnt_next > EXTEND_AFTER) begin
                        secs_next = EXTEND_FACTOR - 7'h01;
                    end else begin
                        secs_next = 7'h00;
                    end
                end
            end
            TSD_WAIT: begin
                if (presc_reg == PRESC_LAST) begin
                    presc_next = 27'h000_0000;
                    if (secs_reg == 7'h00) begin
                        tsd_state_next = TSD_IDLE;
                    end else begin
                        secs_next = secs_reg - 7'h01;
                    end
                end else begin
                    presc_next = presc_reg + 27'h000_0001;
                end
            end
            default: begin
                tsd_state_next = TSD_IDLE;
            end
        endcase
        release_next = (tsd_state_next == TSD_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tsd_state_reg   <= TSD_IDLE;
            evt_cnt_reg     <= 5'h00;
            presc_reg       <= 27'h000_0000;
            secs_reg        <= 7'h00;
            severe_thermal_shutdown_release_ok <= 1'b1;
        end else begin
            tsd_state_reg   <= tsd_state_next;
            evt_cnt_reg     <= evt_cnt_next;
            presc_reg       <= presc_next;
            secs_reg        <= secs_next;
            severe_thermal_shutdown_release_ok <= release_next;
        end
    end

    // ----------------------------------------------------------------
    // read data and decoded settings
    // ----------------------------------------------------------------
    logic [7:0]      rd_next;
    hwcl_cfg_t       cfg_next;
    hwcl_pin_mode_t  pin_mode;

    assign pin_mode = hwcl_pin_mode_t'(pin_reg[2:0]);

    always_comb begin
        // stored bits are masked so reserved positions cannot leak
        case (req.addr)
            HW_ONE_ADDR:  rd_next = hw1_reg & HW_ONE_RW_MASK;
            HW_TWO_ADDR:  rd_next = hw2_reg & HW_TWO_RW_MASK;
            PIN_CFG_ADDR: rd_next = pin_reg & PIN_CFG_RW_MASK;
            default:      rd_next = 8'h00;
        endcase
        cfg_next = '0;
        cfg_next.uv_hys_highest          = hw1_reg[UV_HYS_BIT];
        cfg_next.thermal_wait_extend_sel = hw1_reg[THERM_SEL_BIT];
        cfg_next.reset_delay_reduced     = hw1_reg[RST_DEL_BIT];
        cfg_next.pump_osc_freq_sel = hw2_reg[FREQ_LSB +: 3];
        // reserved codes are flagged so the oscillator can ignore them
        cfg_next.pump_freq_reserved = hw2_reg[FREQ_LSB+2];
        cfg_next.peak_threshold_high = hw2_reg[PEAK_BIT];
        cfg_next.spread_spectrum_rate = hw2_reg[SS_LSB +: 2];
        cfg_next.spread_spectrum_on = |hw2_reg[SS_LSB +: 2];
        case (pin_mode)
            PIN_FAIL_A, PIN_FAIL_B, PIN_FAIL_C: begin
                cfg_next.fail_output = 1'b1;
            end
            PIN_CYCLIC: cfg_next.cyclic_sense  = 1'b1;
            PIN_OFF:    cfg_next.pin_off       = 1'b1;
            PIN_WAKE:   cfg_next.wake_input    = 1'b1;
            PIN_PWM_LS: cfg_next.pwm_low_side  = 1'b1;
            PIN_PWM_HS: cfg_next.pwm_high_side = 1'b1;
            default:    cfg_next.pin_off       = 1'b1;
        endcase
        cfg_next.wake_source_fail_safe =
            fail_safe_mode && (pin_mode == PIN_WAKE);
        // the pump enable lives elsewhere; its owner gates on this
        cfg_next.pump_pin_locked = lock0;
        cfg_next.level1_locked   = lock1_active_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
            cfg     <= '0;
        end else begin
            rd_data <= rd_next;
            cfg     <= cfg_next;
        end
    end
endmodule
`default_nettype wire

// ---- hwcl_sva.sv ----
`default_nettype none
module hwcl_sva
    import hwcl_pkg::*;
#(
    parameter longint TSD_WAIT_CYCLES = WAIT_CYCLES
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire hwcl_req_t         req,
    input wire logic              spi_chip_select_n,
    input wire logic              soft_reset,
    input wire logic              fail_safe_mode,
    input wire logic              severe_thermal_shutdown_event,
    input wire logic              severe_thermal_shutdown_count_clear,
    input wire logic [DATA_W-1:0] rd_data,
    input wire hwcl_cfg_t         cfg,
    input wire logic              severe_thermal_shutdown_release_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // thermal hold length: the wait is too long for a repetition
    // ----------------------------------------------------------------
    longint low_reg;
    longint low_next;
    always_comb begin
        low_next = severe_thermal_shutdown_release_ok ? 0 : low_reg + 1;
    end
    always_ff @(posedge clk) begin
        low_reg <= rst_b ? low_next : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_hw1_rsvd;
        req.addr == HW_ONE_ADDR |=> {rd_data[6], rd_data[2:0]} == 4'h0;
    endproperty
    a_hw1_rsvd: assert property (p_hw1_rsvd)
        else $error("control one reserved bits read set");
    property p_pin_rsvd;
        req.addr == PIN_CFG_ADDR |=> rd_data[7:3] == 5'h00;
    endproperty
    a_pin_rsvd: assert property (p_pin_rsvd)
        else $error("pin config upper bits read set");
    // cfg[8:3] is the pin decode, cfg[19:9] the level-1 settings
    property p_lk0;
        cfg.pump_pin_locked |=> $stable(cfg[8:3]);
    endproperty
    a_lk0: assert property (p_lk0)
        else $error("pin mode changed under level-0 lock");
    property p_lk1;
        cfg.level1_locked |=> $stable(cfg[19:9]);
    endproperty
    a_lk1: assert property (p_lk1)
        else $error("setting changed under level-1 lock");
    property p_lk1_self;
        cfg.level1_locked |=> cfg.level1_locked;
    endproperty
    a_lk1_self: assert property (p_lk1_self)
        else $error("level-1 lock released");
    property p_lk1_cs;
        $rose(cfg.level1_locked) |->
            $past(spi_chip_select_n, 2) && !$past(spi_chip_select_n, 3);
    endproperty
    a_lk1_cs: assert property (p_lk1_cs)
        else $error("level-1 lock without chip-select rise");
    property p_wake;
        cfg.wake_source_fail_safe ==
            ($past(fail_safe_mode) && cfg.wake_input);
    endproperty
    a_wake: assert property (p_wake)
        else $error("fail-safe wake source wrong");
    property p_tsd;
        $rose(severe_thermal_shutdown_release_ok) |->
            low_reg == TSD_WAIT_CYCLES || low_reg == 64 * TSD_WAIT_CYCLES;
    endproperty
    a_tsd: assert property (p_tsd)
        else $error("thermal wait length wrong");
endmodule
bind hwcl_regs hwcl_sva #(.TSD_WAIT_CYCLES(TSD_WAIT_CYCLES)) sva_u (
    .clk(clk), .rst_b(rst_b), .req(req),
    .spi_chip_select_n(spi_chip_select_n), .soft_reset(soft_reset),
    .fail_safe_mode(fail_safe_mode), .severe_thermal_shutdown_event(severe_thermal_shutdown_event),
    .severe_thermal_shutdown_count_clear(severe_thermal_shutdown_count_clear), .rd_data(rd_data), .cfg(cfg),
    .severe_thermal_shutdown_release_ok(severe_thermal_shutdown_release_ok));
`default_nettype wire

// ---- hwcl_tb.sv ----
`default_nettype none
module tb
    import hwcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam longint W = 4;
    logic      clk, rst_b, soft_reset, fail_safe_mode;
    logic      severe_thermal_shutdown_event, severe_thermal_shutdown_count_clear, severe_thermal_shutdown_release_ok;
    logic      spi_chip_select_n;
    logic [7:0] rd_data;
    hwcl_req_t req;
    hwcl_cfg_t cfg;
    int        fail_count = 0;
    int        n_tests = 0;
    hwcl_regs #(.TSD_WAIT_CYCLES(W)) dut_u (.clk(clk), .rst_b(rst_b),
        .req(req), .spi_chip_select_n(spi_chip_select_n),
        .soft_reset(soft_reset), .fail_safe_mode(fail_safe_mode),
        .severe_thermal_shutdown_event(severe_thermal_shutdown_event), .severe_thermal_shutdown_count_clear(severe_thermal_shutdown_count_clear),
        .rd_data(rd_data), .cfg(cfg), .severe_thermal_shutdown_release_ok(severe_thermal_shutdown_release_ok));
    hwcl_host host_u (.clk(clk), .rd_data(rd_data), .req(req),
        .spi_chip_select_n(spi_chip_select_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // shared checks
    // ----------------------------------------------------------------
    task automatic chk(input string s, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %0h seen %0h", s, e, g);
            fail_count++;
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd(a, v);
        chk("read", e, v);
    endtask
    task automatic pulse_soft;
        @(posedge clk) #1;
        soft_reset = 1'b1;
        @(posedge clk) #1;
        soft_reset = 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_hw1;
        host_u.wr(HW_ONE_ADDR, 8'hff);
        rchk(HW_ONE_ADDR, 8'hb8);
        chk("hw1 cfg", 4'hf, {cfg[19:17], cfg.pump_pin_locked});
        host_u.wr(HW_ONE_ADDR, 8'h00);
        rchk(HW_ONE_ADDR, 8'h00);
        chk("hw1 cfg", 4'h0, {cfg[19:17], cfg.pump_pin_locked});
        $display("control one test done");
    endtask
    task automatic t_hw2;
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], i[0], i[1:0], 2'b10};
            host_u.wr(HW_TWO_ADDR, d);
            rchk(HW_TWO_ADDR, d & 8'hfd);
            chk("hw2 cfg", {i[2:0], i[2], i[0], |i[1:0], i[1:0]},
                cfg[16:9]);
        end
        host_u.wr(HW_TWO_ADDR, 8'h40);
        $display("control two test done");
    endtask
    task automatic t_pin;
        fail_safe_mode = 1'b1;
        for (int i = 0; i < 8; i++) begin
            host_u.wr(PIN_CFG_ADDR, {5'h1f, i[2:0]});
            rchk(PIN_CFG_ADDR, i[2:0]);
            chk("pin", i < 3 ? 8'h20 : 8'h20 >> (i - 2), cfg[8:3]);
            chk("wake", i == 5, cfg.wake_source_fail_safe);
        end
        fail_safe_mode = 1'b0;
        $display("pin test done");
    endtask
    task automatic t_lock0;
        host_u.pin_set(3'h6);
        host_u.wr(HW_ONE_ADDR, 8'h38);
        host_u.wr(PIN_CFG_ADDR, 8'h01);
        rchk(PIN_CFG_ADDR, 8'h06);
        pulse_soft();
        rchk(HW_ONE_ADDR, 8'h08);
        rchk(PIN_CFG_ADDR, 8'h06);
        host_u.wr(HW_ONE_ADDR, 8'h00);
        pulse_soft();
        rchk(PIN_CFG_ADDR, 8'h00);
        $display("level-0 lock test done");
    endtask
    task automatic t_thermal;
        int n;
        host_u.wr(HW_ONE_ADDR, 8'h20);
        @(posedge clk) #1;
        severe_thermal_shutdown_count_clear = 1'b1;
        @(posedge clk) #1;
        severe_thermal_shutdown_count_clear = 1'b0;
        for (int k = 1; k <= 18; k++) begin
            if (k == 18) host_u.wr(HW_ONE_ADDR, 8'h00);
            @(posedge clk) #1;
            severe_thermal_shutdown_event = 1'b1;
            @(posedge clk) #1;
            severe_thermal_shutdown_event = 1'b0;
            n = 0;
            while (n < 300) begin
                @(posedge clk) #1;
                n++;
                if (severe_thermal_shutdown_release_ok === 1'b1) break;
            end
            chk("tsd wait", k == 17 ? 64 * W : W, n);
        end
        $display("thermal test done");
    endtask
    task automatic t_lock1;
        host_u.wr(HW_TWO_ADDR, 8'h51);
        host_u.wr(HW_TWO_ADDR, 8'h00);
        rchk(HW_TWO_ADDR, 8'h51);
        host_u.wr(HW_ONE_ADDR, 8'hb8);
        rchk(HW_ONE_ADDR, 8'h08);
        pulse_soft();
        rchk(HW_TWO_ADDR, 8'h51);
        rchk(HW_ONE_ADDR, 8'h08);
        host_u.pin_set(3'h4);
        rchk(PIN_CFG_ADDR, 8'h04);
        chk("lock1", 1'b1, cfg.level1_locked);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        rchk(HW_TWO_ADDR, 8'h40);
        $display("level-1 lock test done");
    endtask
    initial begin
        {rst_b, soft_reset, fail_safe_mode} = 3'h0;
        {severe_thermal_shutdown_event, severe_thermal_shutdown_count_clear} = 2'h0;
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        rchk(HW_ONE_ADDR, 8'h00);
        rchk(HW_TWO_ADDR, 8'h40);
        rchk(PIN_CFG_ADDR, 8'h00);
        rchk(7'h10, 8'h00);
        t_hw1();
        t_hw2();
        t_pin();
        t_lock0();
        t_thermal();
        t_lock1();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
